// *** design/dslt_host.sv ***
// Purpose: host controller end: clock lane, data bursts, turnaround, rate checks
// Assumes: source keeps TX_VALID up through a burst; words carry one byte per lane
// Notes: link clock is CLK/2 driven out; data changes on its falling edge
`timescale 1ns/1ps
`default_nettype none
module dslt_host (
  // system
  input wire logic CLK,
  input wire logic RST,
  // configuration
  input wire logic [2:0] LANE_CNT,
  input wire dslt_pkg::dslt_dt_t DATA_TYPE,
  input wire logic [15:0] V_TOTAL,
  input wire logic [15:0] H_TOTAL,
  // transmit stream
  input wire logic [31:0] TX_WORD,
  input wire logic TX_VALID,
  input wire logic TX_LAST,
  output logic TX_READY,
  // turnaround and status
  input wire logic BTA_REQ,
  output logic BTA_DONE,
  output logic BUSY,
  output logic RATE_OK,
  output logic FRAME_OK,
  // link
  dslt_link_if.host LINK
);
  import dslt_pkg::*;
  typedef enum {H_IDLE, H_CLPX, H_CPREP, H_CZERO, H_CPRE, H_DLPX, H_DPREP, H_DZERO, H_SYNC, H_DATA,
                H_TRAIL, H_CPOST, H_CTRAIL, H_CEXIT, H_TAREQ, H_TAWAIT, H_TAGO, H_TAEND} dslt_hst_e;
  dslt_hst_e st_q;
  dslt_cnt_t cnt_q;
  logic [2:0] bit_q;
  logic [1:0] tstep_q;
  logic last_q, lclk_q, ph, in_shift, clk_run, bit_end, load_word, to_trail, load_sync, zero_ld;
  logic [1:0] d0_s1_q, d0_s2_q, d0_prev_q;
  logic lp_chg;
  logic [7:0] sh_q [LANES];
  logic [LANES-1:0] hs_q, on;
  logic [1:0] clk_lp_q, d0_lp_q;
  logic d0_oe_n_q;
  longint fr;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      d0_s1_q <= LP11;
      d0_s2_q <= LP11;
      d0_prev_q <= LP11;
    end else begin
      d0_s1_q <= LINK.d0_lp;
      d0_s2_q <= d0_s1_q;
      d0_prev_q <= d0_s2_q;
    end
  end
  assign lp_chg = d0_s2_q != d0_prev_q;
  ////////////////////////////////////////////////////////////////////////
  assign in_shift = (st_q == H_DZERO) || (st_q == H_SYNC) || (st_q == H_DATA) || (st_q == H_TRAIL);
  assign clk_run = in_shift || (st_q == H_CPRE) || (st_q == H_DLPX) || (st_q == H_DPREP) || (st_q == H_CPOST);
  // ph marks the edge where the link clock falls, so bits change half a period before sampling
  assign ph = lclk_q;
  assign bit_end = in_shift && ph && (bit_q == 3'h7);
  assign TX_READY = ph && (bit_q == 3'h7) && ((st_q == H_SYNC) || (st_q == H_DATA && !last_q));
  assign load_word = TX_READY && TX_VALID;
  assign load_sync = bit_end && (st_q == H_DZERO);
  assign to_trail = bit_end && ((st_q == H_SYNC) || (st_q == H_DATA)) && !load_word;
  assign zero_ld = (st_q == H_DPREP) && ph && (cnt_q >= HS_PREP_CYC - 8'h01);
  assign on = lanes_on(LANE_CNT);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      tstep_q <= '0;
      last_q <= 1'b0;
      BTA_DONE <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      BTA_DONE <= 1'b0;
      if (in_shift && ph) bit_q <= bit_q + 1'b1;
      unique case (st_q)
        // lp-11 must stand a full lp period before a new request may leave it
        H_IDLE: begin
          tstep_q <= '0;
          if (cnt_q >= LP_CYC - 8'h01) begin
            cnt_q <= LP_CYC - 8'h01;
            if (TX_VALID || BTA_REQ) cnt_q <= '0;
            if (TX_VALID) st_q <= H_CLPX;
            else if (BTA_REQ) st_q <= H_TAREQ;
          end
        end
        H_CLPX: if (at_end(cnt_q, LP_CYC)) begin
          st_q <= H_CPREP;
          cnt_q <= '0;
        end
        H_CPREP: if (at_end(cnt_q, CLK_PREP_CYC)) begin
          st_q <= H_CZERO;
          cnt_q <= '0;
        end
        H_CZERO: if (at_end(cnt_q, CLK_ZERO_CYC)) begin
          st_q <= H_CPRE;
          cnt_q <= '0;
        end
        H_CPRE: if (at_end(cnt_q, CLK_PRE_CYC)) begin
          st_q <= H_DLPX;
          cnt_q <= '0;
        end
        H_DLPX: if (at_end(cnt_q, LP_CYC)) begin
          st_q <= H_DPREP;
          cnt_q <= '0;
        end
        H_DPREP: if (zero_ld) begin
          st_q <= H_DZERO;
          bit_q <= '0;
          last_q <= 1'b0;
        end
        H_DZERO: if (bit_end) st_q <= H_SYNC;
        H_SYNC, H_DATA: begin
          if (load_word) begin
            st_q <= H_DATA;
            last_q <= TX_LAST;
          end else if (to_trail) st_q <= H_TRAIL;
        end
        H_TRAIL: if (bit_end) begin
          st_q <= H_CPOST;
          cnt_q <= '0;
        end
        // post period also covers the data lane LP-11 hold after the burst
        H_CPOST: if (at_end(cnt_q, CLK_POST_CYC)) begin
          st_q <= H_CTRAIL;
          cnt_q <= '0;
        end
        H_CTRAIL: if (at_end(cnt_q, CLK_TRAIL_CYC)) begin
          st_q <= H_CEXIT;
          cnt_q <= '0;
        end
        H_CEXIT: if (at_end(cnt_q, EXIT_CYC)) st_q <= H_IDLE;
        H_TAREQ: if (at_end(cnt_q, LP_CYC)) begin
          cnt_q <= '0;
          tstep_q <= tstep_q + 1'b1;
          if (tstep_q == 2'h3) begin
            st_q <= H_TAWAIT;
            tstep_q <= '0;
          end
        end
        // count the module's entries into LP-10; its LP-00 after the third one hands the lane back
        H_TAWAIT: begin
          if (lp_chg) cnt_q <= '0;
          if (lp_chg && d0_s2_q == LP10) tstep_q <= tstep_q + 1'b1;
          if ((lp_chg && d0_s2_q == LP00 && tstep_q == 2'h3) || at_end(cnt_q, TA_TIMEOUT_CYC)) begin
            st_q <= H_TAGO;
            cnt_q <= '0;
          end
        end
        H_TAGO: if (at_end(cnt_q, TA_GO_CYC)) begin
          st_q <= H_TAEND;
          cnt_q <= '0;
        end
        H_TAEND: if (at_end(cnt_q, LP_CYC)) begin
          st_q <= H_IDLE;
          cnt_q <= '0;
          BTA_DONE <= 1'b1;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        sh_q[i] <= '0;
        hs_q[i] <= 1'b0;
      end else begin
        if (zero_ld) sh_q[i] <= '0;
        else if (load_sync) sh_q[i] <= SYNC_BYTE;
        else if (load_word) sh_q[i] <= TX_WORD[8*i +: 8];
        else if (to_trail) sh_q[i] <= {8{~sh_q[i][0]}};
        else if (in_shift && ph) sh_q[i] <= {1'b0, sh_q[i][7:1]};
        if (in_shift && ph) hs_q[i] <= sh_q[i][0] & on[i];
        else if (!in_shift) hs_q[i] <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lclk_q <= 1'b0;
      clk_lp_q <= LP11;
      d0_lp_q <= LP11;
      d0_oe_n_q <= 1'b0;
    end else begin
      lclk_q <= clk_run ? ~lclk_q : 1'b0;
      unique case (st_q)
        H_CLPX: clk_lp_q <= LP01;
        H_IDLE, H_CEXIT, H_TAREQ, H_TAWAIT, H_TAGO, H_TAEND: clk_lp_q <= LP11;
        default: clk_lp_q <= LP00;
      endcase
      unique case (st_q)
        H_DLPX: d0_lp_q <= LP01;
        H_DPREP, H_DZERO, H_SYNC, H_DATA, H_TRAIL, H_TAGO: d0_lp_q <= LP00;
        H_TAREQ: d0_lp_q <= tstep_q[0] ? LP00 : LP10;
        H_TAEND: d0_lp_q <= LP10;
        default: d0_lp_q <= LP11;
      endcase
      d0_oe_n_q <= (st_q == H_TAWAIT);
    end
  end
  assign LINK.link_clk = lclk_q;
  assign LINK.clk_lp = clk_lp_q;
  assign LINK.hs_dat = hs_q;
  assign LINK.d0_lp_h = d0_lp_q;
  assign LINK.d0_lp_h_oe_n = d0_oe_n_q;
  assign BUSY = (st_q != H_IDLE);
  ////////////////////////////////////////////////////////////////////////
  assign fr = frame_hz(LINK_MBPS, LANE_CNT, V_TOTAL, H_TOTAL, bits_per_pixel(DATA_TYPE));
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      RATE_OK <= 1'b0;
      FRAME_OK <= 1'b0;
    end else begin
      RATE_OK <= LINK_MBPS <= max_lane_mbps(DATA_TYPE, LANE_CNT);
      FRAME_OK <= (fr >= FR_MIN_HZ) && (fr <= ((LANE_CNT == 3'h2) ? FR_MAX_2L_HZ : FR_MAX_NL_HZ));
    end
  end
endmodule : dslt_host
`default_nettype wire

// *** design/dslt_pkg.sv ***
// Purpose: shared constants, codes and helpers for the serial display link model
// Assumes: CLK 100 MHz at both ends; link clock = CLK/2 from the host, one bit per link clock period
// Notes: lane LP pair coded {p,n}; timing counts are CLK cycles
// Operation
// - pixel codes 0e/1e/2e/3e give 16/18/24/24 bits
// - 24-bit formats: 850/650/550 Mbps per lane
// - 565 format: 566/433/366 Mbps per lane
// - packed 666: 637/487/412 Mbps per lane
// - turnaround lp states last 50 to 75 ns
// - module waits one to two periods before driving
// - module drives LP-00 five periods on takeover
// - host drives LP-00 four periods on return
// - host lp states last at least 50 ns
// - data prepare 40+4UI to 85+6UI ns
// - data termination on within 35+4UI ns
// - burst end trailer discarded by skip timeout; module drops it by holding each word back until the next
// - host holds data LP-11 100 ns after burst
// - clock runs 60+52UI ns after data ends
// - clock trail state at least 60 ns
// - clock prepare LP-00 38 to 95 ns
// - clock termination on within 38 ns
// - clock prepare plus zero at least 300 ns
// - clock runs 8UI before data leaves LP
// - host holds clock LP-11 100 ns after burst
// - frame rate from lane rate and totals
// - frame rate 50-60 Hz two lanes, else 50-70
package dslt_pkg;
  localparam int CLK_NS = 10;
  localparam int UI_NS = 2 * CLK_NS;
  localparam int LINK_MBPS = 1000 / UI_NS;
  localparam int LANES = 4;
  localparam int CNT_W = 8;
  typedef logic [CNT_W-1:0] dslt_cnt_t;
  typedef logic [1:0] dslt_lp_t;
  typedef logic [5:0] dslt_dt_t;

  localparam dslt_lp_t LP11 = 2'h3;
  localparam dslt_lp_t LP10 = 2'h2;
  localparam dslt_lp_t LP01 = 2'h1;
  localparam dslt_lp_t LP00 = 2'h0;
  localparam logic [7:0] SYNC_BYTE = 8'hb8;

  localparam dslt_dt_t DT_RGB565 = 6'h0e;
  localparam dslt_dt_t DT_RGB666P = 6'h1e;
  localparam dslt_dt_t DT_RGB666L = 6'h2e;
  localparam dslt_dt_t DT_RGB888 = 6'h3e;

  // lp state period, same figure for both directions
  localparam int LP_NS = 60;
  localparam int TA_SURE_PERIODS = 1;
  localparam int TA_GET_PERIODS = 5;
  localparam int TA_GO_PERIODS = 4;
  localparam int HS_PREP_MIN_NS = 40 + 4 * UI_NS;
  localparam int SKIP_MIN_NS = 40;
  localparam int HS_EXIT_NS = 100;
  localparam int CLK_POST_NS = 60 + 52 * UI_NS;
  localparam int CLK_TRAIL_NS = 60;
  localparam int CLK_PREP_MIN_NS = 38;
  localparam int CLK_LEAD_NS = 300;
  localparam int CLK_PRE_NS = 8 * UI_NS;
  localparam int HS_ZERO_UI = 8;
  localparam int TRAIL_UI = 8;

  localparam dslt_cnt_t LP_CYC = CNT_W'(LP_NS / CLK_NS);
  // host holds its last LP-00 one period, module then waits its own periods
  localparam dslt_cnt_t TA_SURE_CYC = CNT_W'((1 + TA_SURE_PERIODS) * LP_NS / CLK_NS);
  localparam dslt_cnt_t TA_GET_CYC = CNT_W'(TA_GET_PERIODS * LP_NS / CLK_NS);
  localparam dslt_cnt_t TA_GO_CYC = CNT_W'(TA_GO_PERIODS * LP_NS / CLK_NS);
  localparam dslt_cnt_t HS_PREP_CYC = CNT_W'((HS_PREP_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam dslt_cnt_t SKIP_CYC = CNT_W'((SKIP_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam dslt_cnt_t EXIT_CYC = CNT_W'((HS_EXIT_NS + CLK_NS - 1) / CLK_NS);
  localparam dslt_cnt_t CLK_POST_CYC = CNT_W'((CLK_POST_NS + CLK_NS - 1) / CLK_NS);
  localparam dslt_cnt_t CLK_TRAIL_CYC = CNT_W'((CLK_TRAIL_NS + CLK_NS - 1) / CLK_NS);
  localparam dslt_cnt_t CLK_PREP_CYC = CNT_W'((CLK_PREP_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam dslt_cnt_t CLK_ZERO_CYC = CNT_W'((CLK_LEAD_NS + CLK_NS - 1) / CLK_NS) - CLK_PREP_CYC;
  localparam dslt_cnt_t CLK_PRE_CYC = CNT_W'(CLK_PRE_NS / CLK_NS);
  localparam dslt_cnt_t TA_TIMEOUT_CYC = 8'hff;
  localparam int FR_MIN_HZ = 50;
  localparam int FR_MAX_2L_HZ = 60;
  localparam int FR_MAX_NL_HZ = 70;

  function automatic logic at_end(input dslt_cnt_t cnt, input dslt_cnt_t len);
    return cnt == len - 8'h01;
  endfunction : at_end

  function automatic int bits_per_pixel(input dslt_dt_t dt);
    unique case (dt)
      DT_RGB565: return 16;
      DT_RGB666P: return 18;
      default: return 24;
    endcase
  endfunction : bits_per_pixel

  // zero means the lane count or the data type is outside the characterised range
  function automatic int max_lane_mbps(input dslt_dt_t dt, input logic [2:0] lanes);
    int r;
    r = 0;
    unique case (dt)
      DT_RGB565: r = (lanes == 3'h2) ? 566 : (lanes == 3'h3) ? 433 : (lanes == 3'h4) ? 366 : 0;
      DT_RGB666P: r = (lanes == 3'h2) ? 637 : (lanes == 3'h3) ? 487 : (lanes == 3'h4) ? 412 : 0;
      DT_RGB666L, DT_RGB888: r = (lanes == 3'h2) ? 850 : (lanes == 3'h3) ? 650 : (lanes == 3'h4) ? 550 : 0;
      default: r = 0;
    endcase
    return r;
  endfunction : max_lane_mbps

  function automatic longint frame_hz(input int mbps, input logic [2:0] lanes, input logic [15:0] vtot,
                                      input logic [15:0] htot, input int bpp);
    longint num;
    longint den;
    num = longint'(mbps) * 64'd1000000 * longint'(lanes);
    den = longint'(vtot) * longint'(htot) * longint'(bpp);
    return (den == 0) ? 64'd0 : num / den;
  endfunction : frame_hz

  function automatic logic [LANES-1:0] lanes_on(input logic [2:0] cnt);
    logic [LANES-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) m[i] = (i < int'(cnt));
    return m;
  endfunction : lanes_on

  // module side turnaround drive: take (00), own (10,11), return (10,00,10,00)
  function automatic dslt_lp_t ta_pat(input logic [2:0] step);
    unique case (step)
      3'h1, 3'h3, 3'h5: return LP10;
      3'h2: return LP11;
      default: return LP00;
    endcase
  endfunction : ta_pat
endpackage : dslt_pkg

// *** design/dslt_link_if.sv ***
// Purpose: link between host controller and display module ends
// Assumes: lane 0 lp pair is two-way; other lanes follow lane 0 lp timing
// Notes: an undriven lp pair reads LP-00 so both handovers stay glitch free
`timescale 1ns/1ps
`default_nettype none
interface dslt_link_if;
  import dslt_pkg::*;
  logic link_clk;
  logic [1:0] clk_lp;
  logic [LANES-1:0] hs_dat;
  logic [1:0] d0_lp_h;
  logic d0_lp_h_oe_n;
  logic [1:0] d0_lp_d;
  logic d0_lp_d_oe_n;
  logic [1:0] d0_lp;
  assign d0_lp = !d0_lp_h_oe_n ? d0_lp_h : (!d0_lp_d_oe_n ? d0_lp_d : LP00);
  modport host (output link_clk, clk_lp, hs_dat, d0_lp_h, d0_lp_h_oe_n, input d0_lp);
  modport dev (input link_clk, clk_lp, hs_dat, d0_lp, output d0_lp_d, d0_lp_d_oe_n);
endinterface : dslt_link_if
`default_nettype wire

// *** design/dslt_dev.sv ***
// Purpose: display module end: lp state tracking, termination, hs receive, turnaround
// Assumes: link clock runs during bursts and for the post period after them
// Notes: hs receive logic runs on the link clock; words cross to CLK by toggle
`timescale 1ns/1ps
`default_nettype none
module dslt_dev (
  // system
  input wire logic CLK,
  input wire logic RST,
  // configuration
  input wire logic [2:0] LANE_CNT,
  // link
  dslt_link_if.dev LINK,
  // received stream
  output logic [31:0] RX_WORD,
  output logic RX_VALID,
  output logic BURST_ACTIVE,
  output logic DATA_TERM_EN,
  output logic CLK_TERM_EN,
  output logic LANE_OWNED
);
  import dslt_pkg::*;
  typedef enum {D_STOP, D_HSREQ, D_HS, D_SKIP, D_TA1, D_TA2, D_TA3, D_TA4, D_DRIVE, D_WAIT11} dslt_dst_e;
  dslt_dst_e st_q;
  dslt_cnt_t cnt_q;
  logic [2:0] step_q;
  logic [1:0] d0_s1_q, d0_s2_q, d0_prev_q, ck_s1_q, ck_s2_q;
  logic lp_chg, clk_armed_q, hs_en_q;
  logic [1:0] d_lp_q;
  logic d_oe_n_q;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      d0_s1_q <= LP11;
      d0_s2_q <= LP11;
      d0_prev_q <= LP11;
      ck_s1_q <= LP11;
      ck_s2_q <= LP11;
    end else begin
      d0_s1_q <= LINK.d0_lp;
      d0_s2_q <= d0_s1_q;
      d0_prev_q <= d0_s2_q;
      ck_s1_q <= LINK.clk_lp;
      ck_s2_q <= ck_s1_q;
    end
  end
  assign lp_chg = d0_s2_q != d0_prev_q;
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= D_STOP;
      cnt_q <= '0;
      step_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      unique case (st_q)
        D_STOP: if (lp_chg) begin
          cnt_q <= '0;
          st_q <= (d0_s2_q == LP01) ? D_HSREQ : (d0_s2_q == LP10) ? D_TA1 : D_WAIT11;
        end
        D_HSREQ: if (lp_chg) begin
          st_q <= (d0_s2_q == LP00) ? D_HS : (d0_s2_q == LP11) ? D_STOP : D_WAIT11;
        end
        // hs levels read as LP-00, so only LP-11 marks the end of the burst
        D_HS: if (lp_chg && d0_s2_q == LP11) begin
          st_q <= D_SKIP;
          cnt_q <= '0;
        end
        D_SKIP: if (at_end(cnt_q, SKIP_CYC)) st_q <= D_STOP;
        D_TA1: if (lp_chg) st_q <= (d0_s2_q == LP00) ? D_TA2 : D_WAIT11;
        D_TA2: if (lp_chg) st_q <= (d0_s2_q == LP10) ? D_TA3 : D_WAIT11;
        D_TA3: if (lp_chg) begin
          st_q <= (d0_s2_q == LP00) ? D_TA4 : D_WAIT11;
          cnt_q <= '0;
        end
        D_TA4: if (at_end(cnt_q, TA_SURE_CYC)) begin
          st_q <= D_DRIVE;
          cnt_q <= '0;
          step_q <= '0;
        end
        D_DRIVE: if (at_end(cnt_q, (step_q == 3'h0) ? TA_GET_CYC : LP_CYC)) begin
          cnt_q <= '0;
          step_q <= step_q + 1'b1;
          if (step_q == 3'h6) st_q <= D_WAIT11;
        end
        D_WAIT11: if (lp_chg && d0_s2_q == LP11) st_q <= D_STOP;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      d_oe_n_q <= 1'b1;
      d_lp_q <= LP00;
      hs_en_q <= 1'b0;
      clk_armed_q <= 1'b0;
    end else begin
      d_oe_n_q <= !(st_q == D_DRIVE);
      d_lp_q <= ta_pat(step_q);
      hs_en_q <= (st_q == D_HS);
      if (ck_s2_q == LP01) clk_armed_q <= 1'b1;
      else if (ck_s2_q == LP11) clk_armed_q <= 1'b0;
    end
  end
  assign LINK.d0_lp_d = d_lp_q;
  assign LINK.d0_lp_d_oe_n = d_oe_n_q;
  assign DATA_TERM_EN = hs_en_q;
  // combinational from the synchroniser output keeps the delay at two CLK periods
  assign CLK_TERM_EN = clk_armed_q && (ck_s2_q == LP00);
  assign BURST_ACTIVE = hs_en_q;
  assign LANE_OWNED = (st_q == D_DRIVE) && (step_q == 3'h2);
  ////////////////////////////////////////////////////////////////////////
  // link clock domain; reset acts without the link clock since it may be stopped
  logic en_s1_q, en_s2_q, lock_q, tog_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q [LANES];
  logic [7:0] nxt [LANES];
  logic [31:0] word_q, word_nxt;
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign nxt[i] = {LINK.hs_dat[i], sh_q[i][7:1]};
    assign word_nxt[8*i +: 8] = nxt[i];
    always_ff @(posedge LINK.link_clk or posedge RST) begin
      if (RST) sh_q[i] <= '0;
      else sh_q[i] <= nxt[i];
    end
  end
  always_ff @(posedge LINK.link_clk or posedge RST) begin
    if (RST) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      lock_q <= 1'b0;
      bit_q <= '0;
      word_q <= '0;
      tog_q <= 1'b0;
    end else begin
      en_s1_q <= hs_en_q;
      en_s2_q <= en_s1_q;
      if (!en_s2_q) lock_q <= 1'b0;
      else if (!lock_q) begin
        if (nxt[0] == SYNC_BYTE) begin
          lock_q <= 1'b1;
          bit_q <= '0;
        end
      end else begin
        bit_q <= bit_q + 1'b1;
        if (bit_q == 3'h7) begin
          word_q <= word_nxt;
          tog_q <= ~tog_q;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // each word is held back until the next one, so the trailer word dies at burst end
  logic tg_s1_q, tg_s2_q, tg_s3_q, pend_q;
  logic [31:0] pend_word_q, mask;
  logic [LANES-1:0] on;
  assign on = lanes_on(LANE_CNT);
  for (genvar i = 0; i < LANES; i++) begin : g_mask
    assign mask[8*i +: 8] = {8{on[i]}};
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      pend_q <= 1'b0;
      pend_word_q <= '0;
      RX_WORD <= '0;
      RX_VALID <= 1'b0;
    end else begin
      tg_s1_q <= tog_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      RX_VALID <= 1'b0;
      if (st_q != D_HS) pend_q <= 1'b0;
      else if (tg_s2_q ^ tg_s3_q) begin
        pend_q <= 1'b1;
        pend_word_q <= word_q & mask;
        if (pend_q) begin
          RX_WORD <= pend_word_q;
          RX_VALID <= 1'b1;
        end
      end
    end
  end
endmodule : dslt_dev
`default_nettype wire

// *** dv/dslt_sva.sv ***
// Purpose: wire timing checks on the host to module link
// Assumes: sampled on CLK; both ends are design code
// Notes: module status pins are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module dslt_sva
  import dslt_pkg::*;
(
  // system
  input wire logic CLK,
  input wire logic RST,
  // link
  input wire logic link_clk,
  input wire logic [1:0] clk_lp,
  input wire logic [1:0] d0_lp_h,
  input wire logic d0_lp_h_oe_n,
  input wire logic [1:0] d0_lp_d,
  input wire logic d0_lp_d_oe_n,
  input wire logic [1:0] d0_lp
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // cycles since the link clock was last seen high, saturating
  logic [3:0] still_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) still_q <= '0;
    else if (link_clk) still_q <= '0;
    else if (still_q != 4'hf) still_q <= still_q + 4'h1;
  end
  a_clk_trail: assert property ($past(clk_lp) == LP00 && clk_lp == LP11 |-> still_q >= 4'h6)
    else $error("clock trail short");
  a_clk_lp_hold: assert property ($changed(clk_lp) |=> $stable(clk_lp)[*3]) else $error("clock lp short");
  a_zero_lead: assert property ($past(clk_lp) == LP01 && clk_lp == LP00
    |-> (!link_clk throughout ##29 1'b1) ##[1:12] link_clk) else $error("clock lead wrong");
  a_clk_pre_data: assert property ($past(d0_lp) == LP11 && d0_lp == LP01
    |-> $past(link_clk, 15) != $past(link_clk, 14)) else $error("clock not run before data");
  a_d0_lp_hold: assert property ($changed(d0_lp) |=> $stable(d0_lp)[*4]) else $error("data lp short");
  a_data_exit: assert property ($past(d0_lp) == LP00 && d0_lp == LP11
    |-> d0_lp == LP11 throughout ##9 1'b1) else $error("data exit short");
  a_clk_exit: assert property ($past(clk_lp) == LP00 && clk_lp == LP11
    |-> clk_lp == LP11 throughout ##9 1'b1) else $error("clock exit short");
  a_clk_post: assert property ($past(d0_lp) == LP00 && d0_lp == LP11
    |-> ##108 link_clk != $past(link_clk)) else $error("clock stopped early");
  a_ta_wait: assert property ($rose(d0_lp_h_oe_n)
    |-> d0_lp_d_oe_n[*5] ##[1:8] !d0_lp_d_oe_n) else $error("takeover wait wrong");
  a_ta_take: assert property ($fell(d0_lp_d_oe_n)
    |-> (!d0_lp_d_oe_n && d0_lp_d == LP00) throughout ##29 1'b1) else $error("takeover lp00 short");
  a_ta_return: assert property ($fell(d0_lp_h_oe_n)
    |-> d0_lp_h == LP00 throughout ##23 1'b1) else $error("return lp00 short");
endmodule : dslt_sva
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: self-checking bench joining host and module ends
// Assumes: 100 MHz clock; the host end makes the link clock
// Notes: random words and sizes from an xorshift seeded at 46
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dslt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, tx_valid = 1'b0, tx_last = 1'b0, bta_req = 1'b0;
  logic [2:0] lane_cnt = 3'h4;
  dslt_dt_t data_type = DT_RGB888;
  logic [15:0] v_total = 16'h01f4, h_total = 16'h01f4;
  logic [31:0] tx_word = 32'h0, rx_word, seed = 32'h2e;
  logic tx_ready, bta_done, busy, rate_ok, frame_ok, rx_valid, burst_active, data_term_en, clk_term_en, lane_owned;
  logic saw_term = 1'b0, saw_cterm = 1'b0, saw_own = 1'b0;
  logic [31:0] rxq[$], expq[$];
  int err_count = 0, tests_run = 0, cyc = 0;
  dslt_link_if link ();
  dslt_host dslt_host_i (.CLK(clk), .RST(rst), .LANE_CNT(lane_cnt), .DATA_TYPE(data_type), .V_TOTAL(v_total),
    .H_TOTAL(h_total), .TX_WORD(tx_word), .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready),
    .BTA_REQ(bta_req), .BTA_DONE(bta_done), .BUSY(busy), .RATE_OK(rate_ok), .FRAME_OK(frame_ok), .LINK(link));
  dslt_dev dslt_dev_i (.CLK(clk), .RST(rst), .LANE_CNT(lane_cnt), .LINK(link), .RX_WORD(rx_word),
    .RX_VALID(rx_valid), .BURST_ACTIVE(burst_active), .DATA_TERM_EN(data_term_en), .CLK_TERM_EN(clk_term_en),
    .LANE_OWNED(lane_owned));
  dslt_sva dslt_sva_i (.CLK(clk), .RST(rst), .link_clk(link.link_clk), .clk_lp(link.clk_lp), .d0_lp(link.d0_lp),
    .d0_lp_h(link.d0_lp_h), .d0_lp_h_oe_n(link.d0_lp_h_oe_n), .d0_lp_d(link.d0_lp_d),
    .d0_lp_d_oe_n(link.d0_lp_d_oe_n));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // per-lane rate ceiling, zero outside the characterised lane counts
  function automatic int lim(dslt_dt_t dt, int n);
    int t[4][3] = '{'{566, 433, 366}, '{637, 487, 412}, '{850, 650, 550}, '{850, 650, 550}};
    return (n < 2 || n > 4) ? 0 : t[dt[5:4]][n-2];
  endfunction : lim
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  always @(negedge clk) begin
    cyc++;
    if (rx_valid === 1'b1) rxq.push_back(rx_word);
    if (burst_active === 1'b1 && data_term_en === 1'b1) saw_term = 1'b1;
    if (clk_term_en === 1'b1) saw_cterm = 1'b1;
    if (lane_owned === 1'b1) saw_own = 1'b1;
    if (cyc > 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic cfg_test();
    longint fps;
    for (int t = 0; t < 4; t++) begin
      for (int n = 1; n < 6; n++) begin
        @(negedge clk);
        data_type = {t[1:0], 4'he};
        lane_cnt = n[2:0];
        v_total = 16'(300 + rnd() % 200);
        h_total = 16'(400 + rnd() % 200);
        repeat (4) @(negedge clk);
        fps = longint'(LINK_MBPS) * 1000000 * n / (longint'(v_total) * h_total * ((t == 0) ? 16 : (t == 1) ? 18 : 24));
        chk(rate_ok, 32'(LINK_MBPS <= lim(data_type, n)));
        chk(frame_ok, 32'(fps >= 50 && fps <= ((n == 2) ? 60 : 70)));
      end
    end
    $display("config test done");
  endtask : cfg_test
  task automatic burst(int n);
    logic [31:0] m;
    rxq.delete();
    expq.delete();
    saw_term = 1'b0;
    saw_cterm = 1'b0;
    @(negedge clk);
    lane_cnt = 3'(2 + rnd() % 3);
    m = 32'hffffffff >> (8 * (4 - lane_cnt));
    tx_word = rnd();
    tx_last = (n == 1);
    tx_valid = 1'b1;
    for (int i = 1; i <= n; i++) begin
      do @(negedge clk); while (tx_ready !== 1'b1);
      expq.push_back(tx_word & m);
      @(negedge clk);
      tx_word = rnd();
      tx_last = (i == n - 1);
      tx_valid = (i < n);
    end
    do @(negedge clk); while (busy === 1'b1);
    repeat (20) @(negedge clk);
    chk(rxq.size(), expq.size());
    foreach (expq[k]) chk(rxq[k], expq[k]);
    chk(saw_term, 1);
    chk(saw_cterm, 1);
    $display("burst of %0d words on %0d lanes done", n, lane_cnt);
  endtask : burst
  task automatic bta();
    saw_own = 1'b0;
    @(negedge clk);
    bta_req = 1'b1;
    do @(negedge clk); while (bta_done !== 1'b1);
    bta_req = 1'b0;
    chk(saw_own, 1);
    $display("turnaround done");
  endtask : bta
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    cfg_test();
    data_type = DT_RGB888;
    burst(1);
    burst(6);
    repeat (3) burst(1 + rnd() % 6);
    bta();
    burst(2);
    bta();
    bta();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
